// file: rtl/cbr_pkg.sv
// Constants, field layouts and types of the CAN bus-off recovery controller.
// Assumes a 32-bit classic Wishbone register bus and a 100 MHz module clock.
package cbr_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CAUSE = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h0C;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_TX_IDENT = 8'h14;
  localparam logic [7:0] ADDR_FLT_IDENT = 8'h18;
  localparam logic [7:0] ADDR_FLT_MASK = 8'h1C;
  localparam logic [7:0] ADDR_RX_IDENT = 8'h20;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_BOM_LSB = 2;
  localparam int CTRL_FRET_BIT = 4;
  localparam int CTRL_TX_EXT_BIT = 5;
  localparam int CTRL_FLT_EXT_BIT = 6;
  localparam int ST_PASSIVE_BIT = 0;
  localparam int ST_BUS_OFF_BIT = 1;
  localparam int ST_WARN_BIT = 2;
  localparam int ST_MODE_LSB = 3;
  localparam int CNT_REC_LSB = 16;
  localparam int CAUSE_WARN = 0;
  localparam int CAUSE_PASSIVE = 1;
  localparam int CAUSE_BOFF_ENTRY = 2;
  localparam int CAUSE_BOFF_REC = 3;
  localparam int CAUSE_BUS_ERR = 4;
  localparam int CAUSE_W = 5;
  localparam int STD_LSB = 18;
  localparam int STD_W = 11;
  localparam int EXT_W = 18;

  // ---------------------------------------------------------------
  // Codes, reset values and counts
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_OPERATE = 2'h0;
  localparam logic [1:0] MODE_RESET = 2'h1;
  localparam logic [1:0] MODE_HALT = 2'h2;
  localparam logic [1:0] BOM_NORMAL = 2'h0;
  localparam logic [1:0] BOM_HALT_ENTRY = 2'h1;
  localparam logic [1:0] BOM_HALT_END = 2'h2;
  localparam logic [1:0] BOM_HALT_REQ = 2'h3;
  localparam logic [9:0] WARN_LIMIT = 10'h060;
  localparam logic [9:0] PASSIVE_LIMIT = 10'h080;
  localparam logic [9:0] BUS_OFF_LIMIT = 10'h100;
  localparam logic [9:0] REC_MAX = 10'h0FF;
  localparam logic [9:0] TEC_STEP = 10'h008;
  localparam logic [7:0] RECOV_COUNT = 8'h80;

  typedef struct packed {
    logic flt_ext;
    logic tx_ext;
    logic [1:0] bus_off_recovery_mode;
    logic [1:0] mode;
  } cbr_ctrl_t;

  typedef struct packed {
    logic ext;
    logic [10:0] std_id;
    logic [17:0] ext_id;
  } cbr_frame_t;

  typedef enum logic {CBR_ACTIVE, CBR_BUS_OFF} cbr_state_t;

endpackage

// file: rtl/cbr_ctrl.sv
// Error-state counters, bus-off recovery control, error cause flags and
// identifier filter of one CAN channel, behind a classic Wishbone slave.
// Assumes the bit engine supplies synchronous one-cycle event pulses.
//
// Operation
// - Status register shows error-passive and bus-off.
// - Each error event latches in cause register.
// - Repeated transmit errors enter bus-off, stop communicating.
// - Mode 00: 128 recessive runs recover, flag.
// - Mode 00 forced return: active, no flag.
// - Forced-return bit clears itself after write.
// - Mode 01: halt at bus-off entry, entry flag only.
// - Mode 10: recover, flag, then halt.
// - Mode 11: halt request in bus-off halts.
// - Mode 11 without halt request recovers normally.
// - Standard and extended identifiers both supported.
// - Identifier word layout: std b28..18, ext b17..0.
// - Hardware acceptance filter keeps or discards frames.
// - Warning 96, passive 128, bus-off 256 flagged.
// - Error interrupt only for enabled causes.
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module cbr_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic tx_error_i,
  input wire logic rx_error_i,
  input wire logic tx_ok_i,
  input wire logic rx_ok_i,
  input wire logic recessive_run_i,
  input wire logic rx_valid_i,
  input wire cbr_pkg::cbr_frame_t rx_frame_i,
  output logic bus_enable_o,
  output logic [31:0] tx_ident_o,
  output logic accept_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Merges write data into a register under the byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Builds an identifier word, dropping extended bits for standard format.
  function automatic logic [31:0] ident_word(input logic [31:0] w, input logic ext);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[cbr_pkg::STD_LSB +: cbr_pkg::STD_W] = w[cbr_pkg::STD_LSB +: cbr_pkg::STD_W];
    if (ext) begin
      r[cbr_pkg::EXT_W-1:0] = w[cbr_pkg::EXT_W-1:0];
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  cbr_pkg::cbr_ctrl_t ctrl_r, ctrl_nxt;
  cbr_pkg::cbr_state_t state_r, state_nxt;
  logic fret_r, fret_nxt;
  logic [9:0] tec_r, tec_nxt;
  logic [9:0] rec_r, rec_nxt;
  logic [7:0] run_cnt_r, run_cnt_nxt;
  logic [cbr_pkg::CAUSE_W-1:0] cause_r, cause_nxt;
  logic [cbr_pkg::CAUSE_W-1:0] irq_en_r, irq_en_nxt;
  logic [31:0] tx_id_r, tx_id_nxt;
  logic [31:0] flt_id_r, flt_id_nxt;
  logic [31:0] flt_mask_r, flt_mask_nxt;
  logic [31:0] rx_id_r, rx_id_nxt;
  logic accept_r, accept_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;

  logic wr;
  logic in_reset;
  logic [31:0] wmerge;
  logic [31:0] status_w;
  logic [31:0] ctrl_w;
  logic [31:0] rx_word;
  logic [cbr_pkg::CAUSE_W-1:0] set_c;

  assign in_reset = (ctrl_r.mode == cbr_pkg::MODE_RESET);
  assign wr = cyc_i & stb_i & we_i & ack_r;

  always_comb begin
    ctrl_w = 32'h0000_0000;
    ctrl_w[cbr_pkg::CTRL_MODE_LSB +: 2] = ctrl_r.mode;
    ctrl_w[cbr_pkg::CTRL_BOM_LSB +: 2] = ctrl_r.bus_off_recovery_mode;
    ctrl_w[cbr_pkg::CTRL_FRET_BIT] = fret_r;
    ctrl_w[cbr_pkg::CTRL_TX_EXT_BIT] = ctrl_r.tx_ext;
    ctrl_w[cbr_pkg::CTRL_FLT_EXT_BIT] = ctrl_r.flt_ext;
    status_w = 32'h0000_0000;
    status_w[cbr_pkg::ST_PASSIVE_BIT] = (state_r == cbr_pkg::CBR_ACTIVE) &&
                                        ((tec_r >= cbr_pkg::PASSIVE_LIMIT) ||
                                         (rec_r >= cbr_pkg::PASSIVE_LIMIT));
    status_w[cbr_pkg::ST_BUS_OFF_BIT] = (state_r == cbr_pkg::CBR_BUS_OFF);
    status_w[cbr_pkg::ST_WARN_BIT] = (tec_r >= cbr_pkg::WARN_LIMIT) ||
                                     (rec_r >= cbr_pkg::WARN_LIMIT);
    status_w[cbr_pkg::ST_MODE_LSB +: 2] = ctrl_r.mode;
  end

  assign rx_word = {3'h0, rx_frame_i.std_id, rx_frame_i.ext_id};

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic [9:0] tec_t;
    logic [9:0] rec_t;
    logic talk;
    logic enter_off;
    tec_t = tec_r;
    rec_t = rec_r;
    talk = (ctrl_r.mode == cbr_pkg::MODE_OPERATE) && (state_r == cbr_pkg::CBR_ACTIVE);
    enter_off = 1'b0;
    ctrl_nxt = ctrl_r;
    state_nxt = state_r;
    fret_nxt = 1'b0;
    run_cnt_nxt = run_cnt_r;
    set_c = '0;
    irq_en_nxt = irq_en_r;
    tx_id_nxt = tx_id_r;
    flt_id_nxt = flt_id_r;
    flt_mask_nxt = flt_mask_r;
    rx_id_nxt = rx_id_r;
    accept_nxt = 1'b0;
    wmerge = 32'h0000_0000;

    // Error counters move only while the channel takes part in traffic.
    if (talk) begin
      if (tx_error_i) begin
        tec_t = tec_t + cbr_pkg::TEC_STEP;
      end else if (tx_ok_i && tec_t != 10'h000) begin
        tec_t = tec_t - 10'h001;
      end
      if (rx_error_i) begin
        rec_t = (rec_t >= cbr_pkg::REC_MAX) ? cbr_pkg::REC_MAX : rec_t + 10'h001;
      end else if (rx_ok_i && rec_t != 10'h000) begin
        rec_t = rec_t - 10'h001;
      end
      set_c[cbr_pkg::CAUSE_BUS_ERR] = tx_error_i | rx_error_i;
      if ((tec_t >= cbr_pkg::WARN_LIMIT || rec_t >= cbr_pkg::WARN_LIMIT) &&
          !(tec_r >= cbr_pkg::WARN_LIMIT || rec_r >= cbr_pkg::WARN_LIMIT)) begin
        set_c[cbr_pkg::CAUSE_WARN] = 1'b1;
      end
      if ((tec_t >= cbr_pkg::PASSIVE_LIMIT || rec_t >= cbr_pkg::PASSIVE_LIMIT) &&
          !(tec_r >= cbr_pkg::PASSIVE_LIMIT || rec_r >= cbr_pkg::PASSIVE_LIMIT)) begin
        set_c[cbr_pkg::CAUSE_PASSIVE] = 1'b1;
      end
      if (tec_t >= cbr_pkg::BUS_OFF_LIMIT) begin
        tec_t = cbr_pkg::BUS_OFF_LIMIT;
        enter_off = 1'b1;
      end
    end

    // Register writes take effect at the edge where ack is seen.
    if (wr) begin
      case (adr_i[7:0])
        cbr_pkg::ADDR_CTRL: begin
          wmerge = merge(ctrl_w, dat_i, sel_i);
          ctrl_nxt.mode = wmerge[cbr_pkg::CTRL_MODE_LSB +: 2];
          ctrl_nxt.tx_ext = wmerge[cbr_pkg::CTRL_TX_EXT_BIT];
          ctrl_nxt.flt_ext = wmerge[cbr_pkg::CTRL_FLT_EXT_BIT];
          if (in_reset) begin
            ctrl_nxt.bus_off_recovery_mode = wmerge[cbr_pkg::CTRL_BOM_LSB +: 2];
          end
          fret_nxt = wmerge[cbr_pkg::CTRL_FRET_BIT] & sel_i[0];
        end
        cbr_pkg::ADDR_IRQ_EN: begin
          if (in_reset) begin
            wmerge = merge({27'h0, irq_en_r}, dat_i, sel_i);
            irq_en_nxt = wmerge[cbr_pkg::CAUSE_W-1:0];
          end
        end
        cbr_pkg::ADDR_TX_IDENT: tx_id_nxt = merge(tx_id_r, dat_i, sel_i);
        cbr_pkg::ADDR_FLT_IDENT: flt_id_nxt = merge(flt_id_r, dat_i, sel_i);
        cbr_pkg::ADDR_FLT_MASK: flt_mask_nxt = merge(flt_mask_r, dat_i, sel_i);
        default: begin
        end
      endcase
    end

    // Bus-off entry and the three ways out.
    case (state_r)
      cbr_pkg::CBR_ACTIVE: begin
        if (enter_off) begin
          state_nxt = cbr_pkg::CBR_BUS_OFF;
          set_c[cbr_pkg::CAUSE_BOFF_ENTRY] = 1'b1;
          run_cnt_nxt = 8'h00;
          if (ctrl_r.bus_off_recovery_mode == cbr_pkg::BOM_HALT_ENTRY) begin
            state_nxt = cbr_pkg::CBR_ACTIVE;
            ctrl_nxt.mode = cbr_pkg::MODE_HALT;
            tec_t = 10'h000;
            rec_t = 10'h000;
          end
        end
      end
      cbr_pkg::CBR_BUS_OFF: begin
        if (ctrl_r.bus_off_recovery_mode == cbr_pkg::BOM_NORMAL && fret_nxt) begin
          state_nxt = cbr_pkg::CBR_ACTIVE;
          tec_t = 10'h000;
          rec_t = 10'h000;
        end else if (ctrl_r.bus_off_recovery_mode == cbr_pkg::BOM_HALT_REQ && wr &&
                     adr_i[7:0] == cbr_pkg::ADDR_CTRL &&
                     ctrl_nxt.mode == cbr_pkg::MODE_HALT) begin
          state_nxt = cbr_pkg::CBR_ACTIVE;
          tec_t = 10'h000;
          rec_t = 10'h000;
        end else if (recessive_run_i) begin
          run_cnt_nxt = run_cnt_r + 8'h01;
          if (run_cnt_nxt == cbr_pkg::RECOV_COUNT) begin
            state_nxt = cbr_pkg::CBR_ACTIVE;
            set_c[cbr_pkg::CAUSE_BOFF_REC] = 1'b1;
            tec_t = 10'h000;
            rec_t = 10'h000;
            run_cnt_nxt = 8'h00;
            if (ctrl_r.bus_off_recovery_mode == cbr_pkg::BOM_HALT_END) begin
              ctrl_nxt.mode = cbr_pkg::MODE_HALT;
            end
          end
        end
      end
      default: state_nxt = cbr_pkg::CBR_ACTIVE;
    endcase

    // Reset mode clears the error state and the recessive-run count.
    if (in_reset) begin
      state_nxt = cbr_pkg::CBR_ACTIVE;
      tec_t = 10'h000;
      rec_t = 10'h000;
      run_cnt_nxt = 8'h00;
    end
    tec_nxt = tec_t;
    rec_nxt = rec_t;

    // Acceptance filter compares the identifier under the mask.
    if (rx_valid_i && talk) begin
      if ((((ident_word(rx_word, rx_frame_i.ext) ^ flt_id_r) & flt_mask_r) == 32'h0) &&
          (rx_frame_i.ext == ctrl_r.flt_ext)) begin
        accept_nxt = 1'b1;
        rx_id_nxt = ident_word(rx_word, rx_frame_i.ext);
      end
    end

    // Sticky cause flags: a new event wins over a write-one clear.
    cause_nxt = cause_r;
    if (wr && adr_i[7:0] == cbr_pkg::ADDR_CAUSE && sel_i[0]) begin
      cause_nxt = cause_r & ~dat_i[cbr_pkg::CAUSE_W-1:0];
    end
    cause_nxt = cause_nxt | set_c;
  end

  // ---------------------------------------------------------------
  // Wishbone answer
  // ---------------------------------------------------------------
  always_comb begin
    ack_nxt = cyc_i & stb_i & ~ack_r;
    dat_nxt = dat_r;
    if (cyc_i && stb_i && !ack_r) begin
      case (adr_i[7:0])
        cbr_pkg::ADDR_CTRL: dat_nxt = ctrl_w;
        cbr_pkg::ADDR_STATUS: dat_nxt = status_w;
        cbr_pkg::ADDR_CAUSE: dat_nxt = {27'h0, cause_r};
        cbr_pkg::ADDR_IRQ_EN: dat_nxt = {27'h0, irq_en_r};
        cbr_pkg::ADDR_COUNT: dat_nxt = {6'h00, rec_r, 6'h00, tec_r};
        cbr_pkg::ADDR_TX_IDENT: dat_nxt = tx_id_r;
        cbr_pkg::ADDR_FLT_IDENT: dat_nxt = flt_id_r;
        cbr_pkg::ADDR_FLT_MASK: dat_nxt = flt_mask_r;
        cbr_pkg::ADDR_RX_IDENT: dat_nxt = rx_id_r;
        default: dat_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= '{flt_ext: 1'b0, tx_ext: 1'b0, bus_off_recovery_mode: cbr_pkg::BOM_NORMAL,
                  mode: cbr_pkg::MODE_RESET};
      state_r <= cbr_pkg::CBR_ACTIVE;
      fret_r <= 1'b0;
      tec_r <= 10'h000;
      rec_r <= 10'h000;
      run_cnt_r <= 8'h00;
      cause_r <= '0;
      irq_en_r <= '0;
      tx_id_r <= 32'h0000_0000;
      flt_id_r <= 32'h0000_0000;
      flt_mask_r <= 32'h0000_0000;
      rx_id_r <= 32'h0000_0000;
      accept_r <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      state_r <= state_nxt;
      fret_r <= fret_nxt;
      tec_r <= tec_nxt;
      rec_r <= rec_nxt;
      run_cnt_r <= run_cnt_nxt;
      cause_r <= cause_nxt;
      irq_en_r <= irq_en_nxt;
      tx_id_r <= tx_id_nxt;
      flt_id_r <= flt_id_nxt;
      flt_mask_r <= flt_mask_nxt;
      rx_id_r <= rx_id_nxt;
      accept_r <= accept_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  // Halt stays until software writes another mode into the control register.
  assign bus_enable_o = (ctrl_r.mode == cbr_pkg::MODE_OPERATE) &&
                        (state_r == cbr_pkg::CBR_ACTIVE);
  assign tx_ident_o = ident_word(tx_id_r, ctrl_r.tx_ext);
  assign accept_o = accept_r;
  assign irq_o = |(cause_r & irq_en_r);
  assign ack_o = ack_r;
  assign dat_o = dat_r;

endmodule

// file: tb/cbr_sva.sv
// Port checks of the bus-off recovery controller.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module cbr_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic ack_o,
  input wire logic tx_error_i,
  input wire logic rx_error_i,
  input wire logic recessive_run_i,
  input wire logic rx_valid_i,
  input wire logic accept_o,
  input wire logic bus_enable_o,
  input wire logic [31:0] tx_ident_o,
  input wire logic irq_o
);
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic ev;
  assign ev = tx_error_i | rx_error_i | recessive_run_i | (ack_o & we_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ack;
    ack_o;
  endsequence
  a_ack_answer: assert property (s_req |=> s_ack) else $error("no ack");
  a_ack_pulse: assert property (s_ack |=> !ack_o) else $error("ack too long");
  a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !irq_o && !bus_enable_o
    && tx_ident_o == 32'h0) else $error("outputs not idle after reset");
  a_ident_top: assert property (tx_ident_o[31:29] == 3'h0) else $error("top bits set");
  a_ident_write: assert property (!$stable(tx_ident_o) |-> $past(ack_o) && $past(we_i))
    else $error("identifier changed without write");
  a_accept_cause: assert property (accept_o |-> $past(rx_valid_i) && $past(bus_enable_o))
    else $error("accept without frame");
  a_enable_fall: assert property ($fell(bus_enable_o) |-> $past(tx_error_i) || $past(ack_o))
    else $error("left bus without cause");
  a_enable_rise: assert property ($rose(bus_enable_o) |-> $past(recessive_run_i)
    || $past(ack_o)) else $error("joined bus without cause");
  a_irq_rise: assert property ($rose(irq_o) |-> $past(ev)) else $error("irq without event");
endmodule

// file: tb/cbr_node.sv
// Behavioural model of the other nodes on the bus: error, success and idle events.
// Assumes the bench calls its tasks; pulses last one clock.
`timescale 1ns/1ps
module cbr_node (
  input wire logic clk_i,
  output logic [4:0] ev_o,
  output logic rx_valid_o,
  output cbr_pkg::cbr_frame_t rx_frame_o
);
  // ---------------------------------------------------------------
  // Event drivers
  // ---------------------------------------------------------------
  initial begin
    ev_o = 5'h00;
    rx_valid_o = 1'b0;
    rx_frame_o = '0;
  end
  // Bit 0 transmit error, 4 one run of idle bits; repeated errors force bus-off.
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clk_i);
      ev_o <= 5'h01 << k;
      @(posedge clk_i);
      ev_o <= 5'h00;
    end
  endtask
  // The frame lines carry the inverse once the frame is over.
  task automatic send(input cbr_pkg::cbr_frame_t f);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_frame_o <= f;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_frame_o <= ~f;
  endtask
endmodule

// file: tb/can_bus_off_recovery_control_test.sv
// Self-checking bench of the bus-off recovery controller.
// Assumes a 100 MHz clock and the node model on the event inputs.
`timescale 1ns/1ps
module can_bus_off_recovery_control_test;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, bus_enable_o, accept_o, rx_valid_i;
  logic [31:0] adr_i, dat_i, dat_o, tx_ident_o;
  logic [3:0] sel_i;
  logic [4:0] ev;
  cbr_pkg::cbr_frame_t rx_frame_i;
  int errors, samples_checked;
  cbr_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .tx_error_i(ev[0]), .rx_error_i(ev[1]), .tx_ok_i(ev[2]), .rx_ok_i(ev[3]),
    .recessive_run_i(ev[4]), .rx_valid_i(rx_valid_i), .rx_frame_i(rx_frame_i),
    .bus_enable_o(bus_enable_o), .tx_ident_o(tx_ident_o), .accept_o(accept_o), .irq_o(irq_o));
  cbr_node node (.clk_i(clk_i), .ev_o(ev), .rx_valid_o(rx_valid_i), .rx_frame_o(rx_frame_i));
  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {24'h000000, a};
    dat_i <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 50);
    q = dat_o;
    if (t >= 50) begin
      errors++;
      $display("mismatch at %0t: no ack", $time);
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h00000000, q);
    chk(q & m, e);
  endtask
  // Reset mode first, so the recovery mode and interrupt enables are accepted.
  task automatic cfg(input logic [1:0] bus_off_recovery_mode, input logic [4:0] en);
    wr(cbr_pkg::ADDR_CTRL, 32'h00000001);
    wr(cbr_pkg::ADDR_CTRL, {28'h0000000, bus_off_recovery_mode, 2'h1});
    wr(cbr_pkg::ADDR_CAUSE, 32'h0000001F);
    wr(cbr_pkg::ADDR_IRQ_EN, {27'h0, en});
    wr(cbr_pkg::ADDR_CTRL, {28'h0000000, bus_off_recovery_mode, 2'h0});
    node.pulse(0, 32);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_normal;
    rd(cbr_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h00000001);
    cfg(2'h0, 5'h1F);
    rd(cbr_pkg::ADDR_STATUS, 32'hFFFFFFFF, 32'h00000006);
    chk({31'h0, bus_enable_o}, 32'h0);
    rd(cbr_pkg::ADDR_CAUSE, 32'hFFFFFFFF, 32'h00000017);
    chk({31'h0, irq_o}, 32'h1);
    node.pulse(4, 127);
    rd(cbr_pkg::ADDR_STATUS, 32'h00000002, 32'h00000002);
    node.pulse(4, 1);
    rd(cbr_pkg::ADDR_STATUS, 32'hFFFFFFFF, 32'h00000000);
    rd(cbr_pkg::ADDR_CAUSE, 32'h0000000F, 32'h0000000F);
    wr(cbr_pkg::ADDR_CAUSE, 32'h0000001F);
    chk({31'h0, irq_o}, 32'h0);
  endtask
  task automatic t_forced;
    cfg(2'h0, 5'h1F);
    wr(cbr_pkg::ADDR_CTRL, 32'h00000010);
    rd(cbr_pkg::ADDR_CTRL, 32'h00000010, 32'h00000000);
    rd(cbr_pkg::ADDR_STATUS, 32'hFFFFFFFF, 32'h00000000);
    rd(cbr_pkg::ADDR_CAUSE, 32'h00000008, 32'h00000000);
    chk({31'h0, bus_enable_o}, 32'h1);
  endtask
  task automatic t_halt_entry;
    cfg(2'h1, 5'h00);
    rd(cbr_pkg::ADDR_STATUS, 32'h0000001A, 32'h00000010);
    rd(cbr_pkg::ADDR_CAUSE, 32'h0000000C, 32'h00000004);
    chk({31'h0, irq_o}, 32'h0);
    node.pulse(4, 128);
    rd(cbr_pkg::ADDR_STATUS, 32'h00000018, 32'h00000010);
  endtask
  task automatic t_halt_end;
    cfg(2'h2, 5'h1F);
    node.pulse(4, 128);
    rd(cbr_pkg::ADDR_STATUS, 32'h0000001A, 32'h00000010);
    rd(cbr_pkg::ADDR_CAUSE, 32'h00000008, 32'h00000008);
    chk({31'h0, bus_enable_o}, 32'h0);
  endtask
  task automatic t_halt_req;
    cfg(2'h3, 5'h1F);
    wr(cbr_pkg::ADDR_CTRL, 32'h0000000E);
    rd(cbr_pkg::ADDR_STATUS, 32'h0000001A, 32'h00000010);
    rd(cbr_pkg::ADDR_CAUSE, 32'h00000008, 32'h00000000);
    cfg(2'h3, 5'h1F);
    node.pulse(4, 128);
    rd(cbr_pkg::ADDR_STATUS, 32'hFFFFFFFF, 32'h00000000);
    rd(cbr_pkg::ADDR_CAUSE, 32'h00000008, 32'h00000008);
  endtask
  task automatic t_counts;
    wr(cbr_pkg::ADDR_CTRL, 32'h00000001);
    wr(cbr_pkg::ADDR_CAUSE, 32'h0000001F);
    wr(cbr_pkg::ADDR_CTRL, 32'h00000000);
    node.pulse(1, 3);
    node.pulse(3, 1);
    node.pulse(0, 1);
    node.pulse(2, 1);
    rd(cbr_pkg::ADDR_COUNT, 32'hFFFFFFFF, 32'h00020007);
    rd(cbr_pkg::ADDR_CAUSE, 32'h00000013, 32'h00000010);
  endtask
  task automatic t_ident;
    wr(cbr_pkg::ADDR_CTRL, 32'h00000001);
    wr(cbr_pkg::ADDR_TX_IDENT, 32'hFFFFFFFF);
    chk(tx_ident_o, 32'h1FFC0000);
    wr(cbr_pkg::ADDR_CTRL, 32'h00000061);
    chk(tx_ident_o, 32'h1FFFFFFF);
    wr(cbr_pkg::ADDR_FLT_IDENT, {3'h0, 11'h123, 18'h23456});
    wr(cbr_pkg::ADDR_FLT_MASK, 32'h1FFFFFFF);
    wr(cbr_pkg::ADDR_CTRL, 32'h00000060);
    node.send({1'b1, 11'h122, 18'h23456});
    @(negedge clk_i);
    chk({31'h0, accept_o}, 32'h0);
    node.send({1'b0, 11'h123, 18'h00000});
    @(negedge clk_i);
    chk({31'h0, accept_o}, 32'h0);
    node.send({1'b1, 11'h123, 18'h23456});
    @(negedge clk_i);
    chk({31'h0, accept_o}, 32'h1);
    rd(cbr_pkg::ADDR_RX_IDENT, 32'hFFFFFFFF, {3'h0, 11'h123, 18'h23456});
  endtask
  task automatic summarize;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    errors = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 32'h00000000;
    dat_i = 32'h00000000;
    sel_i = 4'hF;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_normal();
    t_forced();
    t_halt_entry();
    t_halt_end();
    t_halt_req();
    t_counts();
    t_ident();
    summarize();
  end
endmodule
bind cbr_ctrl cbr_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .ack_o(ack_o), .tx_error_i(tx_error_i), .rx_error_i(rx_error_i),
  .recessive_run_i(recessive_run_i), .rx_valid_i(rx_valid_i), .accept_o(accept_o),
  .bus_enable_o(bus_enable_o), .tx_ident_o(tx_ident_o), .irq_o(irq_o));
